// >>> logic/tpu_pkg.sv
package tpu_pkg;
  // ==================================================
  // register byte addresses (lower 20 bits)
  localparam logic [19:0] ADDR_PORT_A_DIRECTION = 20'hEE009;
  localparam logic [19:0] ADDR_PORT_A_DATA = 20'hFFFD9;
  localparam logic [19:0] ADDR_PORT_B_DIRECTION = 20'hEE00A;
  localparam logic [19:0] ADDR_PORT_B_DATA = 20'hFFFDA;
  localparam logic [19:0] ADDR_TRIGGER_SELECT = 20'hFFFA1;
  localparam logic [19:0] ADDR_ENABLE_HIGH = 20'hFFFA2;
  localparam logic [19:0] ADDR_ENABLE_LOW = 20'hFFFA3;
  localparam logic [19:0] ADDR_NEXT_UPPER_PAIR = 20'hFFFA4;
  localparam logic [19:0] ADDR_NEXT_LOWER_PAIR = 20'hFFFA5;
  localparam logic [19:0] ADDR_NEXT_GROUP_TWO_ALT = 20'hFFFA6;
  localparam logic [19:0] ADDR_NEXT_GROUP_ZERO_ALT = 20'hFFFA7;
  // ==================================================
  // reset and read-back values
  localparam logic [7:0] RESET_ZERO = 8'h00;
  localparam logic [7:0] RESET_TRIGGER_SELECT = 8'hFF;
  localparam logic [7:0] READ_ALL_ONES = 8'hFF;
  localparam logic [3:0] NIBBLE_ONES = 4'hF;
  // ==================================================
  // trigger select field positions (low bit of each 2-bit field)
  localparam int GRP0_SEL_POS = 0;
  localparam int GRP1_SEL_POS = 2;
  localparam int GRP2_SEL_POS = 4;
  localparam int GRP3_SEL_POS = 6;
  localparam logic [1:0] SEL_CHANNEL0 = 2'h0;
  localparam logic [1:0] SEL_CHANNEL1 = 2'h1;
endpackage

// >>> logic/tpu_timed_pattern_unit.sv
// Design decision made here: the address-and-strobe port.
`timescale 1ns/10ps

// Operation
// - port B data bits with upper enable set ignore software writes.
// - selected compare match copies lower-bank next data into port A data.
// - lower-bank next data clears on reset and hardware standby only.
// - shared trigger groups 0/1: byte at FFFA5, FFFA7 reads ones, unwritable.
// - split trigger groups 0/1: group 1 high nibble FFFA5, group 0 low FFFA7.
// - selected compare match copies upper-bank next data into port B data.
// - upper-bank next data clears on reset and hardware standby only.
// - shared trigger groups 2/3: byte at FFFA4, FFFA6 reads ones, unwritable.
// - split trigger groups 2/3: group 3 high nibble FFFA4, group 2 low FFFA6.
// - lower enable bit gates each next-data copy into port A.
// - lower enable register clears on reset and hardware standby.
// - upper enable bit gates each next-data copy into port B.
// - upper enable register clears on reset and hardware standby.
// - trigger select loads FF on reset and hardware standby.
// - group 3 field bits 7:6: 00 ch0, 01 ch1, 1x ch2.
// - group 2 field bits 5:4: 00 ch0, 01 ch1, 1x ch2.
// - group 1 field bits 3:2, 00 selects channel 0.
// - group 0 field bits 1:0; 01 channel 1, 1x channel 2.
// - pin drives pattern only with direction and enable both set.
module tpu_timed_pattern_unit (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic hw_standby_in,
  // register port
  input wire logic [19:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  // compare-match pulses of timer channels 0..2
  input wire logic [2:0] cmp_match_in,
  // pattern pins 15..0 and their drive enables (active low)
  output logic [15:0] pattern_pin_out,
  output logic [15:0] pattern_pin_oe_n_out
);

  typedef struct packed {
    logic [7:0] port_a_direction;
    logic [7:0] port_a_output_data;
    logic [7:0] port_b_direction;
    logic [7:0] port_b_output_data;
    logic [7:0] next_data_lower_bank;
    logic [7:0] next_data_upper_bank;
    logic [7:0] next_data_enable_low;
    logic [7:0] next_data_enable_high;
    logic [7:0] group_trigger_select;
    logic [7:0] rdata;
    logic [15:0] pin;
    logic [15:0] pin_oe_n;
  } tpu_state_t;

  tpu_state_t state;
  tpu_state_t next_state;

  // ==================================================
  // trigger decode
  function automatic logic tpu_group_trig(input logic [1:0] sel, input logic [2:0] cm);
    logic hit;
    hit = 1'b0;
    case (sel)
      tpu_pkg::SEL_CHANNEL0: hit = cm[0];
      tpu_pkg::SEL_CHANNEL1: hit = cm[1];
      default: hit = cm[2];
    endcase
    return hit;
  endfunction

  // apply copy for one nibble: enabled bits take next data
  function automatic logic [3:0] tpu_copy(input logic [3:0] cur, input logic [3:0] nxt,
                                          input logic [3:0] en, input logic trig);
    return trig ? ((nxt & en) | (cur & ~en)) : cur;
  endfunction

  logic [1:0] sel0;
  logic [1:0] sel1;
  logic [1:0] sel2;
  logic [1:0] sel3;
  logic same01;
  logic same23;
  logic [3:0] trig;

  always_comb begin
    sel0 = state.group_trigger_select[tpu_pkg::GRP0_SEL_POS +: 2];
    sel1 = state.group_trigger_select[tpu_pkg::GRP1_SEL_POS +: 2];
    sel2 = state.group_trigger_select[tpu_pkg::GRP2_SEL_POS +: 2];
    sel3 = state.group_trigger_select[tpu_pkg::GRP3_SEL_POS +: 2];
    // codes 10 and 11 both mean channel 2, so compare the decoded channel
    same01 = (sel0[1] & sel1[1]) | (sel0 == sel1);
    same23 = (sel2[1] & sel3[1]) | (sel2 == sel3);
    trig[0] = tpu_group_trig(sel0, cmp_match_in);
    trig[1] = tpu_group_trig(sel1, cmp_match_in);
    trig[2] = tpu_group_trig(sel2, cmp_match_in);
    trig[3] = tpu_group_trig(sel3, cmp_match_in);
  end

  // ==================================================
  // next state
  always_comb begin
    logic [7:0] rd;
    logic [7:0] na;
    logic [7:0] nb;
    rd = tpu_pkg::RESET_ZERO;
    next_state = state;
    na = state.port_a_output_data;
    nb = state.port_b_output_data;

    // software writes; enabled port data bits stay read-only
    if (wr_in) begin
      case (addr_in)
        tpu_pkg::ADDR_PORT_A_DIRECTION: next_state.port_a_direction = wdata_in;
        tpu_pkg::ADDR_PORT_B_DIRECTION: next_state.port_b_direction = wdata_in;
        tpu_pkg::ADDR_PORT_A_DATA:
          na = (wdata_in & ~state.next_data_enable_low) | (na & state.next_data_enable_low);
        tpu_pkg::ADDR_PORT_B_DATA:
          nb = (wdata_in & ~state.next_data_enable_high) | (nb & state.next_data_enable_high);
        tpu_pkg::ADDR_TRIGGER_SELECT: next_state.group_trigger_select = wdata_in;
        tpu_pkg::ADDR_ENABLE_HIGH: next_state.next_data_enable_high = wdata_in;
        tpu_pkg::ADDR_ENABLE_LOW: next_state.next_data_enable_low = wdata_in;
        tpu_pkg::ADDR_NEXT_UPPER_PAIR: begin
          next_state.next_data_upper_bank[7:4] = wdata_in[7:4];
          if (same23) begin
            next_state.next_data_upper_bank[3:0] = wdata_in[3:0];
          end
        end
        tpu_pkg::ADDR_NEXT_GROUP_TWO_ALT: begin
          if (!same23) begin
            next_state.next_data_upper_bank[3:0] = wdata_in[3:0];
          end
        end
        tpu_pkg::ADDR_NEXT_LOWER_PAIR: begin
          next_state.next_data_lower_bank[7:4] = wdata_in[7:4];
          if (same01) begin
            next_state.next_data_lower_bank[3:0] = wdata_in[3:0];
          end
        end
        tpu_pkg::ADDR_NEXT_GROUP_ZERO_ALT: begin
          if (!same01) begin
            next_state.next_data_lower_bank[3:0] = wdata_in[3:0];
          end
        end
        default: ;
      endcase
    end

    // compare-match transfer on the same edge; it overrides a software write
    na[3:0] = tpu_copy(na[3:0], state.next_data_lower_bank[3:0],
                       state.next_data_enable_low[3:0], trig[0]);
    na[7:4] = tpu_copy(na[7:4], state.next_data_lower_bank[7:4],
                       state.next_data_enable_low[7:4], trig[1]);
    nb[3:0] = tpu_copy(nb[3:0], state.next_data_upper_bank[3:0],
                       state.next_data_enable_high[3:0], trig[2]);
    nb[7:4] = tpu_copy(nb[7:4], state.next_data_upper_bank[7:4],
                       state.next_data_enable_high[7:4], trig[3]);
    next_state.port_a_output_data = na;
    next_state.port_b_output_data = nb;

    // read data, shown the cycle after the strobe
    if (rd_in) begin
      case (addr_in)
        tpu_pkg::ADDR_PORT_A_DATA: rd = state.port_a_output_data;
        tpu_pkg::ADDR_PORT_B_DATA: rd = state.port_b_output_data;
        tpu_pkg::ADDR_TRIGGER_SELECT: rd = state.group_trigger_select;
        tpu_pkg::ADDR_ENABLE_HIGH: rd = state.next_data_enable_high;
        tpu_pkg::ADDR_ENABLE_LOW: rd = state.next_data_enable_low;
        tpu_pkg::ADDR_NEXT_UPPER_PAIR:
          rd = same23 ? state.next_data_upper_bank
                      : {state.next_data_upper_bank[7:4], tpu_pkg::NIBBLE_ONES};
        tpu_pkg::ADDR_NEXT_GROUP_TWO_ALT:
          rd = same23 ? tpu_pkg::READ_ALL_ONES
                      : {tpu_pkg::NIBBLE_ONES, state.next_data_upper_bank[3:0]};
        tpu_pkg::ADDR_NEXT_LOWER_PAIR:
          rd = same01 ? state.next_data_lower_bank
                      : {state.next_data_lower_bank[7:4], tpu_pkg::NIBBLE_ONES};
        tpu_pkg::ADDR_NEXT_GROUP_ZERO_ALT:
          rd = same01 ? tpu_pkg::READ_ALL_ONES
                      : {tpu_pkg::NIBBLE_ONES, state.next_data_lower_bank[3:0]};
        // direction registers are write-only and unmapped addresses read zero
        default: rd = tpu_pkg::RESET_ZERO;
      endcase
    end
    next_state.rdata = rd;

    // pins follow the registered port data; driven when direction and enable set
    next_state.pin = {nb, na};
    next_state.pin_oe_n = ~({next_state.port_b_direction, next_state.port_a_direction}
                            & {next_state.next_data_enable_high,
                               next_state.next_data_enable_low});
  end

  // ==================================================
  // state register; software standby is not a reset, so contents persist
  always_ff @(posedge clk_in) begin
    if (reset_in || hw_standby_in) begin
      state <= '0;
      state.group_trigger_select <= tpu_pkg::RESET_TRIGGER_SELECT;
      state.pin_oe_n <= 16'hFFFF;
    end else begin
      state <= next_state;
    end
  end

  assign rdata_out = state.rdata;
  assign pattern_pin_out = state.pin;
  assign pattern_pin_oe_n_out = state.pin_oe_n;

endmodule

// >>> verification/tpu_cmp_src.sv
`timescale 1ns/10ps
// ==========
// timer channel compare-match source, fires after a chosen delay
module tpu_cmp_src (
  // clock, reset and requests
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic [2:0] fire_in,
  input wire logic [3:0] delay_in,
  // one-cycle compare-match pulses
  output logic [2:0] cmp_match_out
);
  logic [2:0] pend;
  logic [3:0] cnt;
  always_ff @(posedge clk_in) begin
    cmp_match_out <= 3'h0;
    if (reset_in) pend <= 3'h0;
    else if (fire_in != 3'h0) begin
      pend <= fire_in;
      cnt <= delay_in;
    end else if (pend != 3'h0 && cnt == 4'h0) begin
      cmp_match_out <= pend;
      pend <= 3'h0;
    end else cnt <= cnt - 4'h1;
  end
endmodule

// >>> verification/tpu_chk.sv
`timescale 1ns/10ps
// ==========
// port-level checker
module tpu_chk (
  // watched ports
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic hw_standby_in,
  input wire logic [19:0] addr_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [7:0] rdata_out,
  input wire logic [2:0] cmp_match_in,
  input wire logic [15:0] pattern_pin_out,
  input wire logic [15:0] pattern_pin_oe_n_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);
  property p_hws_pins; hw_standby_in |=> !pattern_pin_out && &pattern_pin_oe_n_out; endproperty
  a_hws_pins: assert property (p_hws_pins) else $error("standby left pins set");
  property p_tsel_hws;
    hw_standby_in ##1 (rd_in && !hw_standby_in && addr_in == 20'hFFFA1) |=> rdata_out == 8'hFF;
  endproperty
  a_tsel_hws: assert property (p_tsel_hws) else $error("trigger select not FF");
  property p_next_hws; hw_standby_in ##1 (rd_in && !hw_standby_in && addr_in inside
    {20'hFFFA4, 20'hFFFA5}) |=> rdata_out == 8'h00; endproperty
  a_next_hws: assert property (p_next_hws) else $error("next data not cleared");
  property p_alt_hws; hw_standby_in ##1 (rd_in && !hw_standby_in && addr_in inside
    {20'hFFFA6, 20'hFFFA7}) |=> rdata_out == 8'hFF; endproperty
  a_alt_hws: assert property (p_alt_hws) else $error("reserved byte not ones");
  property p_dir_rd; rd_in && addr_in == 20'hEE00A |=> rdata_out == 8'h00; endproperty
  a_dir_rd: assert property (p_dir_rd) else $error("direction read not zero");
  property p_lo_hold; !hw_standby_in && !cmp_match_in && !(wr_in && addr_in == 20'hFFFD9)
    |=> $stable(pattern_pin_out[7:0]); endproperty
  a_lo_hold: assert property (p_lo_hold) else $error("low pins moved");
  property p_hi_hold; !hw_standby_in && !cmp_match_in && !(wr_in && addr_in == 20'hFFFDA)
    |=> $stable(pattern_pin_out[15:8]); endproperty
  a_hi_hold: assert property (p_hi_hold) else $error("high pins moved");
  property p_oe_hold; !hw_standby_in && !wr_in && !$past(wr_in) && !$past(hw_standby_in)
    |=> $stable(pattern_pin_oe_n_out); endproperty
  a_oe_hold: assert property (p_oe_hold) else $error("drive enable moved");
endmodule
bind tpu_timed_pattern_unit tpu_chk i_chk (.clk_in, .reset_in, .hw_standby_in, .addr_in,
  .wr_in, .rd_in, .rdata_out, .cmp_match_in, .pattern_pin_out, .pattern_pin_oe_n_out);

// >>> verification/tb.sv
`timescale 1ns/10ps
module tb;
  logic clk_in = 0, reset_in = 1, hw_standby_in = 0, wr_in = 0, rd_in = 0;
  logic [19:0] addr_in = 20'h00000;
  logic [7:0] wdata_in = 8'h00, rdata_out;
  logic [7:0] rv [7] = '{8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF};
  logic [7:0] cf [2][5] = '{'{8'h00, 8'hFF, 8'hFF, 8'hC3, 8'h5A},
    '{8'hBA, 8'hF0, 8'h0F, 8'h11, 8'h22}};
  logic [7:0] sw [4] = '{8'hA5, 8'h3C, 8'h7E, 8'h69};
  logic [7:0] sr [4] = '{8'hAF, 8'h3F, 8'hFE, 8'hF9};
  logic [2:0] fire = 3'h0, cmp_match_in;
  logic [3:0] dly = 4'h0;
  logic [15:0] pattern_pin_out, pattern_pin_oe_n_out;
  int bad_count = 0, checks = 0, cyc = 0;
  initial forever #10 clk_in = ~clk_in;
  tpu_timed_pattern_unit i_dut (.clk_in, .reset_in, .hw_standby_in, .addr_in, .wdata_in,
    .wr_in, .rd_in, .rdata_out, .cmp_match_in, .pattern_pin_out, .pattern_pin_oe_n_out);
  tpu_cmp_src i_src (.clk_in, .reset_in, .fire_in(fire), .delay_in(dly),
    .cmp_match_out(cmp_match_in));
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch at %0t: got %h, expected %h", $time, g, e);
    end
  endtask
  // ==========
  // one bus cycle, optionally right after a standby pulse
  task automatic acc(input bit w, input logic [19:0] a, input logic [7:0] d, input bit hs = 0);
    @(posedge clk_in);
    hw_standby_in <= hs;
    @(posedge clk_in);
    hw_standby_in <= 1'b0;
    addr_in <= a;
    wdata_in <= d;
    wr_in <= w;
    rd_in <= !w;
    @(posedge clk_in);
    wr_in <= 1'b0;
    rd_in <= 1'b0;
    if (!w) begin
      @(negedge clk_in);
      chk({8'h00, rdata_out}, {8'h00, d});
    end
  endtask
  task automatic fc(input logic [2:0] c, input logic [3:0] d, input logic [15:0] e);
    @(posedge clk_in);
    fire <= c;
    dly <= d;
    @(posedge clk_in);
    fire <= 3'h0;
    repeat (int'(d) + 3) @(posedge clk_in);
    @(negedge clk_in);
    chk(pattern_pin_out, e);
  endtask
  task automatic wrap_up;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // ==========
  // run length guard, tests need about 160 cycles
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 1000) begin
      bad_count++;
      wrap_up();
    end
  end
  initial begin
    repeat (2) @(posedge clk_in);
    reset_in <= 1'b0;
    for (int i = 0; i < 7; i++) acc(0, 20'hFFFA1 + 20'(i), rv[i]);
    acc(0, 20'h00000, 8'h00);
    acc(1, 20'hEE009, 8'hFF);
    acc(1, 20'hEE00A, 8'hFF);
    acc(0, 20'hEE00A, 8'h00);
    for (int i = 0; i < 5; i++) acc(1, 20'hFFFA1 + 20'(i), cf[0][i]);
    acc(1, 20'hFFFA7, 8'h00);
    acc(0, 20'hFFFA7, 8'hFF);
    acc(0, 20'hFFFA6, 8'hFF);
    chk(pattern_pin_oe_n_out, 16'h0000);
    fc(3'h1, 4'h0, 16'hC35A);
    acc(1, 20'hFFFDA, 8'h00);
    acc(0, 20'hFFFDA, 8'hC3);
    acc(1, 20'hFFFA1, 8'hD4);
    for (int i = 0; i < 4; i++) begin
      acc(1, 20'hFFFA4 + 20'(i), sw[i]);
      acc(0, 20'hFFFA4 + 20'(i), sr[i]);
    end
    fc(3'h2, 4'h5, 16'hCE3A);
    fc(3'h4, 4'h1, 16'hAE3A);
    fc(3'h1, 4'h0, 16'hAE39);
    for (int i = 0; i < 5; i++) acc(1, 20'hFFFA1 + 20'(i), cf[1][i]);
    acc(0, 20'hFFFA3, 8'h0F);
    chk(pattern_pin_oe_n_out, 16'h0FF0);
    fc(3'h4, 4'h3, 16'h1E32);
    acc(1, 20'hFFFDA, 8'h00);
    acc(0, 20'hFFFDA, 8'h10);
    acc(0, 20'hFFFA1, 8'hFF, 1);
    acc(0, 20'hFFFA5, 8'h00, 1);
    acc(0, 20'hFFFA7, 8'hFF, 1);
    acc(0, 20'hFFFA4, 8'h00);
    chk(pattern_pin_out, 16'h0000);
    wrap_up();
  end
endmodule
